// ===== hw/sfe_pkg.sv
/*
 * Shared constants and types of the serial flash erase and deep sleep link:
 * opcodes, timing counts, address splits and the host controller's registers.
 * Assumes a 200 MHz system clock on both ends.
 */
package sfe_pkg;
	// Opcodes on the serial input line.
	localparam logic [7:0] OP_SECTOR = 8'h20;
	localparam logic [7:0] OP_BLK32 = 8'h52;
	localparam logic [7:0] OP_BLK64 = 8'hd8;
	localparam logic [7:0] OP_CHIP_A = 8'h60;
	localparam logic [7:0] OP_CHIP_B = 8'hc7;
	localparam logic [7:0] OP_SLEEP = 8'hb9;
	localparam logic [7:0] OP_WAKE = 8'hab;
	localparam logic [7:0] OP_UNLOCK = 8'h06;
	localparam logic [7:0] OP_STATUS = 8'h05;

	// Frame lengths in serial clock edges.
	localparam logic [5:0] BITS_OPCODE = 6'h08;
	localparam logic [5:0] BITS_ADDR_CMD = 6'h20;
	localparam logic [5:0] BITS_READ_CMD = 6'h10;
	localparam logic [5:0] BITS_SATURATE = 6'h3f;

	// Timing; cycles derived from the 200 MHz clock.
	localparam int CLK_MHZ = 200;
	localparam int T_DP_NS = 3000;
	localparam int DP_CYCLES = (T_DP_NS * CLK_MHZ + 999) / 1000;
	localparam int T_RES_NS = 3000;
	localparam int RES_CYCLES = (T_RES_NS * CLK_MHZ + 999) / 1000;
	localparam int T_SECTOR_US = 50000;
	localparam int T_BLK32_US = 150000;
	localparam int T_BLK64_US = 250000;
	localparam int T_CHIP_US = 8000000;
	localparam int SECTOR_CYCLES = T_SECTOR_US * CLK_MHZ;
	localparam int BLK32_CYCLES = T_BLK32_US * CLK_MHZ;
	localparam int BLK64_CYCLES = T_BLK64_US * CLK_MHZ;
	localparam int CHIP_CYCLES = T_CHIP_US * CLK_MHZ;
	localparam int SCLK_HALF_CYCLES = 16;
	localparam int GAP_CYCLES = 8;

	// Address split of the array.
	localparam int ARRAY_BITS = 20;
	localparam int SECTOR_BITS = 12;
	localparam int BLK32_BITS = 15;
	localparam int BLK64_BITS = 16;
	localparam int PROT_FINE_BITS = 12;
	localparam int PROT_COARSE_BITS = 16;

	// Device status byte layout.
	localparam int STAT_PENDING_BIT = 0;
	localparam int STAT_UNLOCK_BIT = 1;

	// Host controller registers and fields.
	localparam logic [7:0] REG_CMD = 8'h00;
	localparam logic [7:0] REG_ADDR = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam int CMD_LEN_LSB = 8;
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_RDATA_LSB = 8;
	localparam logic [23:0] ADDR_RESET = 24'h000000;
	localparam logic [7:0] RDATA_RESET = 8'h00;

	typedef enum logic [1:0] {KIND_SECTOR, KIND_BLK32, KIND_BLK64, KIND_CHIP} sfe_kind_type;
	typedef enum logic [1:0] {LEN_OPCODE, LEN_ADDR, LEN_READ, LEN_SPARE} sfe_len_type;
endpackage

// ===== hw/sfe_link_if.sv
/*
 * Serial link between host controller and flash device.
 * Assumes the bench joins one host and one device end.
 */
`timescale 1ns/10ps
`default_nettype none
interface sfe_link_if;
	logic cs_n;
	logic sclk;
	logic si;
	logic so;
	modport dev (input cs_n, input sclk, input si, output so);
	modport host (output cs_n, output sclk, output si, input so);
endinterface
`default_nettype wire

// ===== hw/sfe_sync.sv
/*
 * Two flip-flop synchroniser for signals from outside the clock domain.
 * Assumes each bit is a slow level relative to clk_sys.
 */
`timescale 1ns/10ps
`default_nettype none
module sfe_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	input  wire logic             clk_sys,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta;

	// The first stage feeds only the second stage.
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta <= RESET_VAL;
			q <= RESET_VAL;
		end
		else
		begin
			meta <= d;
			q <= meta;
		end
	end
endmodule
`default_nettype wire

// ===== hw/sfe_flash_dev.sv
/*
 * Flash device end: decodes erase, write unlock, status read, deep sleep
 * and wake commands and runs the self-timed cycles.
 * Assumes the link pins arrive asynchronously; rst_n stands for power-up.
 */
// The placing of the registers and the AHB-Lite register port were decided locally.
`timescale 1ns/10ps
`default_nettype none
module sfe_flash_dev #(
	parameter int unsigned SECTOR_TIME = sfe_pkg::SECTOR_CYCLES,
	parameter int unsigned BLK32_TIME  = sfe_pkg::BLK32_CYCLES,
	parameter int unsigned BLK64_TIME  = sfe_pkg::BLK64_CYCLES,
	parameter int unsigned CHIP_TIME   = sfe_pkg::CHIP_CYCLES
) (
	input  wire logic           clk_sys,
	input  wire logic           rst_n,
	sfe_link_if.dev             link,
	input  wire logic [4:0]     protect_range,
	output logic                op_pending_flag,
	output logic                write_unlock_flag,
	output logic                deep_sleep,
	output logic                erase_go,
	output sfe_pkg::sfe_kind_type erase_kind,
	output logic [23:0]         erase_base
);
	import sfe_pkg::*;

	typedef enum {ST_STANDBY, ST_BUSY, ST_ENTERING, ST_SLEEP, ST_WAKING} sfe_dstate_type;

	sfe_dstate_type state;
	logic [2:0]     sync_q;
	logic           s_cs_n;
	logic           s_sclk;
	logic           s_si;
	logic           cs_d;
	logic           sclk_d;
	logic           cs_rise;
	logic           cs_fall;
	logic           sclk_rise;
	logic           sclk_fall;
	logic [31:0]    shift;
	logic [5:0]     cnt;
	logic [7:0]     first_byte;
	logic [7:0]     stat_sh;
	logic [7:0]     stat_byte;
	logic           rd_stat;
	logic [31:0]    timer;
	logic           short_ok;
	logic           long_ok;
	logic [7:0]     op8;
	logic [7:0]     op32;
	logic           awake;
	logic           stat_so_q;

	// True when the erase unit at a overlaps the protected range.
	function automatic logic prot_hit(input logic [23:0] a, input int ub, input logic [4:0] bp);
		int          s;
		logic [31:0] lo;
		logic [31:0] hi;
		s = (bp[4] ? PROT_FINE_BITS : PROT_COARSE_BITS) + int'(bp[2:0]) - 1;
		lo = {8'h00, a} & ((32'h1 << ARRAY_BITS) - 32'h1) & ~((32'h1 << ub) - 32'h1);
		hi = lo | ((32'h1 << ub) - 32'h1);
		if (bp[2:0] == 3'h0)
			return 1'b0;
		if (s >= ARRAY_BITS)
			return 1'b1;
		if (bp[3])
			return lo < (32'h1 << s);
		return hi >= ((32'h1 << ARRAY_BITS) - (32'h1 << s));
	endfunction

	sfe_sync #(.WIDTH(3), .RESET_VAL(3'h4)) u_sync (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.d       ({link.cs_n, link.sclk, link.si}),
		.q       (sync_q)
	);

	// Edge detection on the synchronised pins.
	assign s_cs_n = sync_q[2];
	assign s_sclk = sync_q[1];
	assign s_si = sync_q[0];
	assign cs_rise = s_cs_n & ~cs_d;
	assign cs_fall = ~s_cs_n & cs_d;
	assign sclk_rise = s_sclk & ~sclk_d & ~s_cs_n;
	assign sclk_fall = ~s_sclk & sclk_d & ~s_cs_n;
	assign link.so = stat_so_q;

	// Frame decode used at select release.
	always_comb
	begin
		short_ok = (cnt == BITS_OPCODE);
		long_ok = (cnt == BITS_ADDR_CMD);
		op8 = shift[7:0];
		op32 = shift[31:24];
		awake = (state != ST_SLEEP) && (state != ST_WAKING);
		stat_byte = 8'h00;
		stat_byte[STAT_PENDING_BIT] = op_pending_flag;
		stat_byte[STAT_UNLOCK_BIT] = write_unlock_flag;
	end

	// Previous pin levels for edge detection.
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cs_d <= 1'b1;
			sclk_d <= 1'b0;
		end
		else
		begin
			cs_d <= s_cs_n;
			sclk_d <= s_sclk;
		end
	end

	// Input shifter, MSB first, with a saturating edge count.
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			shift <= 32'h00000000;
			cnt <= 6'h00;
			first_byte <= 8'h00;
		end
		else if (cs_fall)
		begin
			cnt <= 6'h00;
			first_byte <= 8'h00;
		end
		else if (sclk_rise)
		begin
			shift <= {shift[30:0], s_si};
			if (cnt != BITS_SATURATE)
				cnt <= cnt + 6'h01;
			if (cnt == BITS_OPCODE - 6'h01)
				first_byte <= {shift[6:0], s_si};
		end
	end

	// Status byte output, shifted on falling clock, repeated while selected.
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rd_stat <= 1'b0;
			stat_sh <= 8'h00;
			stat_so_q <= 1'b0;
		end
		else if (cs_rise || cs_fall)
		begin
			rd_stat <= 1'b0;
			stat_so_q <= 1'b0;
		end
		else if (sclk_rise && cnt == BITS_OPCODE - 6'h01 && awake
			&& {shift[6:0], s_si} == OP_STATUS)
		begin
			rd_stat <= 1'b1;
			stat_sh <= stat_byte;
		end
		else if (sclk_fall && rd_stat)
		begin
			stat_so_q <= stat_sh[7];
			stat_sh <= {stat_sh[6:0], stat_sh[7]};
		end
	end

	// Command execution and self-timed cycles.
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state <= ST_STANDBY;
			timer <= 32'h00000000;
			op_pending_flag <= 1'b0;
			write_unlock_flag <= 1'b0;
			deep_sleep <= 1'b0;
			erase_go <= 1'b0;
			erase_kind <= KIND_SECTOR;
			erase_base <= 24'h000000;
		end
		else
		begin
			erase_go <= 1'b0;
			case (state)
				ST_STANDBY:
				begin
					if (cs_rise)
					begin
						if (short_ok && op8 == OP_UNLOCK)
							write_unlock_flag <= 1'b1;
						else if (short_ok && op8 == OP_SLEEP)
						begin
							state <= ST_ENTERING;
							timer <= 32'(DP_CYCLES - 1);
						end
						else if (short_ok && (op8 == OP_CHIP_A || op8 == OP_CHIP_B)
							&& write_unlock_flag && protect_range == 5'h00)
						begin
							state <= ST_BUSY;
							timer <= CHIP_TIME - 32'h1;
							op_pending_flag <= 1'b1;
							write_unlock_flag <= 1'b0;
							erase_go <= 1'b1;
							erase_kind <= KIND_CHIP;
							erase_base <= 24'h000000;
						end
						else if (long_ok && write_unlock_flag)
						begin
							if (op32 == OP_SECTOR && !prot_hit(shift[23:0], SECTOR_BITS,
								protect_range))
							begin
								state <= ST_BUSY;
								timer <= SECTOR_TIME - 32'h1;
								op_pending_flag <= 1'b1;
								write_unlock_flag <= 1'b0;
								erase_go <= 1'b1;
								erase_kind <= KIND_SECTOR;
								erase_base <= {shift[23:SECTOR_BITS], 12'h000};
							end
							else if (op32 == OP_BLK32 && !prot_hit(shift[23:0], BLK32_BITS,
								protect_range))
							begin
								state <= ST_BUSY;
								timer <= BLK32_TIME - 32'h1;
								op_pending_flag <= 1'b1;
								write_unlock_flag <= 1'b0;
								erase_go <= 1'b1;
								erase_kind <= KIND_BLK32;
								erase_base <= {shift[23:BLK32_BITS], 15'h0000};
							end
							else if (op32 == OP_BLK64 && !prot_hit(shift[23:0], BLK64_BITS,
								protect_range))
							begin
								state <= ST_BUSY;
								timer <= BLK64_TIME - 32'h1;
								op_pending_flag <= 1'b1;
								write_unlock_flag <= 1'b0;
								erase_go <= 1'b1;
								erase_kind <= KIND_BLK64;
								erase_base <= {shift[23:BLK64_BITS], 16'h0000};
							end
						end
					end
				end
				ST_BUSY:
				begin
					// Every command but status read is ignored here.
					if (timer == 32'h00000000)
					begin
						op_pending_flag <= 1'b0;
						state <= ST_STANDBY;
					end
					else
						timer <= timer - 32'h1;
				end
				ST_ENTERING:
				begin
					if (timer == 32'h00000000)
					begin
						deep_sleep <= 1'b1;
						state <= ST_SLEEP;
					end
					else
						timer <= timer - 32'h1;
				end
				ST_SLEEP:
				begin
					if (cs_rise && cnt >= BITS_OPCODE && first_byte == OP_WAKE)
					begin
						state <= ST_WAKING;
						timer <= 32'(RES_CYCLES - 1);
					end
				end
				ST_WAKING:
				begin
					if (timer == 32'h00000000)
					begin
						deep_sleep <= 1'b0;
						state <= ST_STANDBY;
					end
					else
						timer <= timer - 32'h1;
				end
				default:
					state <= ST_STANDBY;
			endcase
		end
	end
endmodule
`default_nettype wire

// ===== hw/sfe_host_ctl.sv
/*
 * Host SPI controller: AHB-Lite register slave that sends one command frame
 * at a time to the flash device and returns a read byte.
 * Assumes one AHB-Lite master with single word transfers.
 */
`timescale 1ns/10ps
`default_nettype none
module sfe_host_ctl (
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	sfe_link_if.host         link,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata
);
	import sfe_pkg::*;

	typedef enum {H_IDLE, H_LOW, H_HIGH, H_HOLD, H_GAP} sfe_hstate_type;

	sfe_hstate_type state;
	logic           pend;
	logic           pend_wr;
	logic [7:0]     pend_addr;
	logic           start_req;
	logic [7:0]     cmd_op;
	sfe_len_type    cmd_len;
	logic [23:0]    addr_reg;
	logic           busy;
	logic [7:0]     rdata;
	logic [31:0]    tx_sh;
	logic [7:0]     rx_sh;
	logic [5:0]     nbits;
	logic [5:0]     bitcnt;
	logic [4:0]     div;
	logic           tick;
	logic [15:0]    gap;
	logic           s_so;
	logic           cs_n_q;
	logic           sclk_q;
	logic           si_q;

	sfe_sync #(.WIDTH(1), .RESET_VAL(1'b0)) u_sync (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.d       (link.so),
		.q       (s_so)
	);

	assign link.cs_n = cs_n_q;
	assign link.sclk = sclk_q;
	assign link.si = si_q;
	assign tick = (div == 5'(SCLK_HALF_CYCLES - 1));

	// AHB-Lite slave with one wait state; writes land in the data phase.
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			hrdata <= 32'h00000000;
			pend <= 1'b0;
			pend_wr <= 1'b0;
			pend_addr <= 8'h00;
			start_req <= 1'b0;
			cmd_op <= 8'h00;
			cmd_len <= LEN_OPCODE;
			addr_reg <= ADDR_RESET;
		end
		else
		begin
			start_req <= 1'b0;
			hresp <= 1'b0;
			if (pend)
			begin
				pend <= 1'b0;
				hreadyout <= 1'b1;
				hrdata <= 32'h00000000;
				if (pend_wr && pend_addr == REG_CMD && !busy && !start_req)
				begin
					cmd_op <= hwdata[7:0];
					cmd_len <= sfe_len_type'(hwdata[CMD_LEN_LSB +: 2]);
					start_req <= 1'b1;
				end
				else if (pend_wr && pend_addr == REG_ADDR)
					addr_reg <= hwdata[23:0];
				else if (!pend_wr && pend_addr == REG_CMD)
					hrdata <= {22'h000000, cmd_len, cmd_op};
				else if (!pend_wr && pend_addr == REG_ADDR)
					hrdata <= {8'h00, addr_reg};
				else if (!pend_wr && pend_addr == REG_STATUS)
				begin
					hrdata[ST_BUSY_BIT] <= busy | start_req;
					hrdata[ST_RDATA_LSB +: 8] <= rdata;
				end
			end
			else if (hsel && htrans[1] && hready)
			begin
				pend <= 1'b1;
				pend_wr <= hwrite;
				pend_addr <= haddr[7:0];
				hreadyout <= 1'b0;
			end
		end
	end

	// Half-period divider for the serial clock.
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			div <= 5'h00;
		else if (state == H_IDLE || tick)
			div <= 5'h00;
		else
			div <= div + 5'h01;
	end

	// Frame sequencer: select low, MSB first on falling edges, select high.
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state <= H_IDLE;
			busy <= 1'b0;
			cs_n_q <= 1'b1;
			sclk_q <= 1'b0;
			si_q <= 1'b0;
			tx_sh <= 32'h00000000;
			rx_sh <= 8'h00;
			nbits <= 6'h00;
			bitcnt <= 6'h00;
			gap <= 16'h0000;
			rdata <= RDATA_RESET;
		end
		else
		begin
			case (state)
				H_IDLE:
				begin
					if (start_req)
					begin
						busy <= 1'b1;
						cs_n_q <= 1'b0;
						si_q <= cmd_op[7];
						tx_sh <= {cmd_op, (cmd_len == LEN_ADDR) ? addr_reg : 24'h000000};
						nbits <= (cmd_len == LEN_ADDR) ? BITS_ADDR_CMD
							: (cmd_len == LEN_READ) ? BITS_READ_CMD : BITS_OPCODE;
						bitcnt <= 6'h00;
						state <= H_LOW;
					end
				end
				H_LOW:
				begin
					if (tick)
					begin
						sclk_q <= 1'b1;
						if (bitcnt >= BITS_OPCODE)
							rx_sh <= {rx_sh[6:0], s_so};
						state <= H_HIGH;
					end
				end
				H_HIGH:
				begin
					if (tick)
					begin
						sclk_q <= 1'b0;
						bitcnt <= bitcnt + 6'h01;
						tx_sh <= {tx_sh[30:0], 1'b0};
						si_q <= tx_sh[30];
						state <= (bitcnt + 6'h01 == nbits) ? H_HOLD : H_LOW;
					end
				end
				H_HOLD:
				begin
					if (tick)
					begin
						cs_n_q <= 1'b1;
						rdata <= rx_sh;
						gap <= (cmd_op == OP_WAKE) ? 16'(RES_CYCLES + GAP_CYCLES)
							: 16'(GAP_CYCLES);
						state <= H_GAP;
					end
				end
				H_GAP:
				begin
					if (gap == 16'h0000)
					begin
						busy <= 1'b0;
						state <= H_IDLE;
					end
					else
						gap <= gap - 16'h0001;
				end
				default:
					state <= H_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

// ===== tb/sfe_link_properties.sv
/*
 * Concurrent checks on the serial link and on the flash end's status outputs.
 * Assumes one clk_sys domain and an instance placed beside the link by the bench.
 */
`timescale 1ns/10ps
`default_nettype none
module sfe_link_properties #(
	parameter int SHORT_TIME = 50,
	parameter int CHIP_TIME  = 1000
) (
	input wire logic                  clk_sys,
	input wire logic                  rst_n,
	input wire logic                  cs_n,
	input wire logic                  sclk,
	input wire logic                  si,
	input wire logic [4:0]            protect_range,
	input wire logic                  op_pending_flag,
	input wire logic                  write_unlock_flag,
	input wire logic                  deep_sleep,
	input wire logic                  erase_go,
	input wire sfe_pkg::sfe_kind_type erase_kind,
	input wire logic [23:0]           erase_base
);
	import sfe_pkg::*;

	localparam int SLEEP_DELAY = 600;
	logic [15:0]  since_rise;
	int           pend_cnt;
	int           exp_len;
	sfe_kind_type kind_q;

	// Counts cycles since chip select last rose, saturating so old frames never wrap.
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			since_rise <= 16'hffff;
		else if ($rose(cs_n))
			since_rise <= 16'h0000;
		else if (since_rise != 16'hffff)
			since_rise <= since_rise + 16'h0001;
	end

	// Measures each busy period and remembers the kind of erase that began it.
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pend_cnt <= 0;
			kind_q <= KIND_SECTOR;
		end
		else
		begin
			pend_cnt <= op_pending_flag ? pend_cnt + 1 : 0;
			if (erase_go)
				kind_q <= erase_kind;
		end
	end

	// Expected busy length for the erase in progress.
	assign exp_len = (kind_q == KIND_CHIP) ? CHIP_TIME : SHORT_TIME;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	AST_GO_AFTER_CS_RISE: assert property (
		erase_go |-> cs_n && since_rise <= 16'd8)
		else $error("Erase started away from a chip select rise.");
	AST_PENDING_AFTER_GO: assert property (
		erase_go |-> ##[0:1] op_pending_flag)
		else $error("Pending flag missing after erase start.");
	AST_PENDING_LENGTH: assert property (
		$fell(op_pending_flag) |-> pend_cnt >= exp_len && pend_cnt <= exp_len + 2)
		else $error("Busy period has the wrong length.");
	AST_UNLOCK_CLEARED: assert property (
		erase_go |=> !write_unlock_flag [*3])
		else $error("Unlock flag kept after erase start.");
	AST_GO_NEEDS_UNLOCK: assert property (
		erase_go |-> $past(write_unlock_flag) || $past(write_unlock_flag, 2))
		else $error("Erase started without the unlock flag.");
	AST_BASE_ALIGNED: assert property (
		erase_go |-> (erase_base & (erase_kind == KIND_SECTOR ? 24'h000fff :
			erase_kind == KIND_BLK32 ? 24'h007fff :
			erase_kind == KIND_BLK64 ? 24'h00ffff : 24'hffffff)) == 24'h000000)
		else $error("Erase base not aligned to its unit.");
	AST_CHIP_UNPROTECTED: assert property (
		erase_go && erase_kind == KIND_CHIP |-> protect_range == 5'h00)
		else $error("Whole array erase ran with protection set.");
	AST_NO_ERASE_ASLEEP: assert property (
		deep_sleep |-> !erase_go)
		else $error("Erase started during deep sleep.");
	AST_SLEEP_NOT_BUSY: assert property (
		op_pending_flag |-> !deep_sleep)
		else $error("Deep sleep entered during an erase.");
	AST_SLEEP_ENTRY_DELAY: assert property (
		$rose(deep_sleep) |-> since_rise >= SLEEP_DELAY && since_rise <= SLEEP_DELAY + 10)
		else $error("Deep sleep entry delay wrong.");
	AST_WAKE_DELAY: assert property (
		$fell(deep_sleep) |-> since_rise >= RES_CYCLES && since_rise <= RES_CYCLES + 10)
		else $error("Wake recovery delay wrong.");
	AST_SCLK_IDLE_LOW: assert property (
		cs_n |-> !sclk)
		else $error("Serial clock not low while deselected.");
	AST_SI_STABLE_AT_RISE: assert property (
		$rose(sclk) |-> $stable(si))
		else $error("Serial input moved at a rising clock edge.");

	COV_ERASE: cover property (erase_go);
	COV_SLEEP: cover property ($rose(deep_sleep));
	COV_WAKE: cover property ($fell(deep_sleep));
endmodule
`default_nettype wire

// ===== tb/tb_serial_flash_erase_and_deep_sleep.sv
/*
 * Self-checking bench: host controller and flash end joined by the link,
 * driven through AHB-Lite register accesses.
 * Assumes short self-timed lengths on the flash end, set below.
 */
`timescale 1ns/10ps
`default_nettype none
module tb_serial_flash_erase_and_deep_sleep;
	import sfe_pkg::*;

	localparam int SHORT_T     = 50;
	localparam int CHIP_T      = 1000;
	localparam int SLEEP_DELAY = 600;
	logic         clk_sys;
	logic         rst_n = 1'b0;
	logic [31:0]  haddr = 32'h0;
	logic [1:0]   htrans = 2'h0;
	logic         hwrite = 1'b0;
	logic [31:0]  hwdata = 32'h0;
	logic         hreadyout;
	logic         hresp;
	logic [31:0]  hrdata;
	logic [4:0]   protect_range = 5'h00;
	logic         op_pending_flag;
	logic         write_unlock_flag;
	logic         deep_sleep;
	logic         erase_go;
	sfe_kind_type erase_kind;
	logic [23:0]  erase_base;
	logic         sclk_q = 1'b0;
	logic         cs_q = 1'b1;
	logic [31:0]  shreg = 32'h0;
	int           nbits = 0;
	int           n_go = 0;
	sfe_kind_type go_kind = KIND_SECTOR;
	logic [23:0]  go_base = 24'h0;
	int           n_errors = 0;
	int           n_checks = 0;
	logic [7:0]   t_op [5] = '{OP_SECTOR, OP_BLK32, OP_BLK64, OP_CHIP_A, OP_CHIP_B};
	logic [1:0]   t_len [5] = '{2'h1, 2'h1, 2'h1, 2'h0, 2'h0};
	logic [23:0]  t_addr [5] = '{24'h012345, 24'h0abcde, 24'h0abcde, 24'h0, 24'h0};
	logic [23:0]  t_base [5] = '{24'h012000, 24'h0a8000, 24'h0a0000, 24'h0, 24'h0};
	sfe_kind_type t_kind [5] = '{KIND_SECTOR, KIND_BLK32, KIND_BLK64, KIND_CHIP, KIND_CHIP};

	sfe_link_if u_sfe_link_if ();
	wire logic cs_l = u_sfe_link_if.cs_n;
	wire logic sclk_l = u_sfe_link_if.sclk;
	wire logic si_l = u_sfe_link_if.si;

	sfe_host_ctl u_sfe_host_ctl (
		.clk_sys(clk_sys), .rst_n(rst_n), .link(u_sfe_link_if.host), .hsel(1'b1),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
	sfe_flash_dev #(.SECTOR_TIME(SHORT_T), .BLK32_TIME(SHORT_T), .BLK64_TIME(SHORT_T),
		.CHIP_TIME(CHIP_T)) u_sfe_flash_dev (
		.clk_sys(clk_sys), .rst_n(rst_n), .link(u_sfe_link_if.dev),
		.protect_range(protect_range), .op_pending_flag(op_pending_flag),
		.write_unlock_flag(write_unlock_flag), .deep_sleep(deep_sleep),
		.erase_go(erase_go), .erase_kind(erase_kind), .erase_base(erase_base));
	sfe_link_properties #(.SHORT_TIME(SHORT_T), .CHIP_TIME(CHIP_T)) u_sfe_link_properties (
		.clk_sys(clk_sys), .rst_n(rst_n), .cs_n(cs_l), .sclk(sclk_l), .si(si_l),
		.protect_range(protect_range), .op_pending_flag(op_pending_flag),
		.write_unlock_flag(write_unlock_flag), .deep_sleep(deep_sleep),
		.erase_go(erase_go), .erase_kind(erase_kind), .erase_base(erase_base));

	// Free-running system clock.
	initial
	begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	// Collects the bits seen on rising serial clock edges and each erase start.
	always @(posedge clk_sys)
	begin
		sclk_q <= sclk_l;
		cs_q <= cs_l;
		if (cs_q && !cs_l)
		begin
			nbits <= 0;
			shreg <= 32'h0;
		end
		else if (!cs_l && sclk_l && !sclk_q)
		begin
			nbits <= nbits + 1;
			shreg <= {shreg[30:0], si_l};
		end
		if (erase_go === 1'b1)
		begin
			n_go <= n_go + 1;
			go_kind <= erase_kind;
			go_base <= erase_base;
		end
	end

	// Prints the verdict and ends the run.
	task automatic tally_and_finish();
		if (n_errors == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// Compares one value and reports a mismatch at once.
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// One AHB-Lite single word transfer; read data is taken with the second ready.
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		rd = hrdata;
		chk("hresp", 32'h0, hresp);
	endtask

	// Sends one frame through the host, waits until it is done, checks the wire.
	task automatic frame(input logic [7:0] op, input logic [1:0] len, input logic [23:0] a);
		int nb;
		logic [31:0] rd;
		nb = (len == 2'h1) ? 32 : (len == 2'h2) ? 16 : 8;
		xfer(1'b1, REG_ADDR, {8'h0, a}, rd);
		xfer(1'b1, REG_CMD, {22'h0, len, op}, rd);
		rd = 32'h1;
		while (rd[ST_BUSY_BIT] !== 1'b0)
			xfer(1'b0, REG_STATUS, 32'h0, rd);
		chk("bit count", nb, nbits);
		chk("opcode bits", op, shreg[nb-1 -: 8]);
		if (len == 2'h1)
			chk("address bits", a, shreg[23:0]);
		chk("idle select and clock", 32'h2, {30'h0, cs_l, sclk_l});
	endtask

	// Unlocks, issues one erase and checks whether and how it ran.
	task automatic erase(input logic [7:0] op, input logic [1:0] len, input logic [23:0] a,
		input logic go, input sfe_kind_type k, input logic [23:0] base);
		int g;
		g = n_go;
		frame(OP_UNLOCK, 2'h0, 24'h0);
		chk("unlock set", 1, write_unlock_flag);
		frame(op, len, a);
		chk("erase count", g + go, n_go);
		if (go)
		begin
			chk("kind", k, go_kind);
			chk("base", base, go_base);
			chk("unlock cleared", 0, write_unlock_flag);
			chk("pending set", 1, op_pending_flag);
			repeat ((k == KIND_CHIP ? CHIP_T : SHORT_T) + 10) @(posedge clk_sys);
			chk("pending cleared", 0, op_pending_flag);
		end
	endtask

	// Cuts a hung run short.
	initial
	begin
		repeat (90000) @(posedge clk_sys);
		n_errors++;
		tally_and_finish();
	end

	// Main sequence.
	initial
	begin
		logic [31:0] rd;
		repeat (4) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk_sys);
		chk("asleep at power-up", 0, deep_sleep);
		xfer(1'b0, REG_ADDR, 32'h0, rd);
		chk("address reset", {8'h0, ADDR_RESET}, rd);
		xfer(1'b0, 8'h0c, 32'h0, rd);
		chk("unmapped read", 0, rd);
		frame(OP_SECTOR, 2'h1, 24'h012345);
		chk("erase without unlock", 0, n_go);
		for (int i = 0; i < 5; i++)
		begin
			erase(t_op[i], t_len[i] ^ 2'h1, t_addr[i], 1'b0, t_kind[i], t_base[i]);
			erase(t_op[i], t_len[i], t_addr[i], 1'b1, t_kind[i], t_base[i]);
		end
		protect_range <= 5'h01;
		erase(OP_SECTOR, 2'h1, 24'h0ff123, 1'b0, KIND_SECTOR, 24'h0);
		erase(OP_BLK64, 2'h1, 24'h0f8000, 1'b0, KIND_BLK64, 24'h0);
		erase(OP_CHIP_B, 2'h0, 24'h0, 1'b0, KIND_CHIP, 24'h0);
		erase(OP_BLK32, 2'h1, 24'h0e9abc, 1'b1, KIND_BLK32, 24'h0e8000);
		protect_range <= 5'h10;
		erase(OP_CHIP_A, 2'h0, 24'h0, 1'b0, KIND_CHIP, 24'h0);
		protect_range <= 5'h00;
		frame(OP_SLEEP, 2'h1, 24'h0);
		repeat (SLEEP_DELAY + 20) @(posedge clk_sys);
		chk("asleep after long frame", 0, deep_sleep);
		frame(OP_UNLOCK, 2'h0, 24'h0);
		frame(OP_CHIP_A, 2'h0, 24'h0);
		frame(OP_SLEEP, 2'h0, 24'h0);
		chk("erase undisturbed", 1, op_pending_flag);
		repeat (CHIP_T) @(posedge clk_sys);
		chk("asleep after busy request", 0, deep_sleep);
		frame(OP_SLEEP, 2'h0, 24'h0);
		chk("asleep before delay", 0, deep_sleep);
		repeat (SLEEP_DELAY) @(posedge clk_sys);
		chk("asleep", 1, deep_sleep);
		frame(OP_UNLOCK, 2'h0, 24'h0);
		chk("unlock while asleep", 0, write_unlock_flag);
		frame(OP_WAKE, 2'h0, 24'h0);
		repeat (RES_CYCLES) @(posedge clk_sys);
		chk("awake", 0, deep_sleep);
		frame(OP_UNLOCK, 2'h0, 24'h0);
		chk("unlock after wake", 1, write_unlock_flag);
		frame(OP_STATUS, 2'h2, 24'h0);
		xfer(1'b0, REG_STATUS, 32'h0, rd);
		chk("status byte", 32'h02, rd[15:8]);
		tally_and_finish();
	end
endmodule
`default_nettype wire
